// ==== design/csm_regs.svh ====
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

// Register byte offsets on the AXI4-Lite port
`define CSM_OFS_DATA     5'h00
`define CSM_OFS_CTRL     5'h04
`define CSM_OFS_BAUD     5'h08
`define CSM_OFS_STAT     5'h0C
`define CSM_OFS_IRQ_STAT 5'h10
`define CSM_OFS_IRQ_MASK 5'h14
`define CSM_OFS_OUT_EN   5'h18
`define CSM_OFS_START    5'h1C

// Control field positions
`define CSM_CTRL_MD      0
`define CSM_CTRL_DAP     1
`define CSM_CTRL_CKP     2
`define CSM_CTRL_LSB     3
`define CSM_CTRL_LEN7    4

// Interrupt status bits
`define CSM_IRQ_XFER     0
`define CSM_IRQ_OVR      1

// Reset values
`define CSM_CTRL_RST     5'h00
`define CSM_BAUD_RST     12'h0FF
`define CSM_MASK_RST     2'h0

// Frame figures in half serial clock periods, last index
`define CSM_LAST_K8      4'hF
`define CSM_LAST_K7      4'hD

// Smallest allowed upper divider value, giving one quarter of the clock
`define CSM_DIV_HI_MIN   7'h01

// AXI responses
`define CSM_RESP_OKAY    2'h0
`define CSM_RESP_SLVERR  2'h2

`endif

// ==== design/csm_pkg.sv ====
package csm_pkg;

	typedef struct packed {
		logic len7;
		logic lsb_first;
		logic clock_polarity_select;
		logic data_phase_select;
		logic single_continuous_select;
	} ctrl_t;

	typedef struct packed {
		logic [3:0] prescale_exp;
		logic [7:0] baud_divider_field;
	} baud_t;

	typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;

endpackage

// ==== design/in_sync.sv ====
`timescale 1ns/10ps
module in_sync
(
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_q;

	// Two stages before anything reads the pin
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ==== design/baud_gen.sv ====
`timescale 1ns/10ps
module baud_gen
	import csm_pkg::*;
(
	input  wire logic  core_clk_i,
	input  wire logic  reset_i,
	input  wire logic  restart_i,
	input  wire baud_t baud_i,
	output logic       tick_o
);
	`include "csm_regs.svh"

	logic [6:0]  div_hi;
	logic [22:0] half_len;
	logic [22:0] cnt_q;
	logic        hit;

	// Upper divider below one is clamped so the rate never passes a quarter
	assign div_hi   = (baud_i.baud_divider_field[7:1] < `CSM_DIV_HI_MIN) ?
		`CSM_DIV_HI_MIN : baud_i.baud_divider_field[7:1];
	// Half period is (upper divider + 1) shifted by the prescale exponent
	assign half_len = 23'({16'h0000, div_hi} + 23'h000001) << baud_i.prescale_exp;
	assign hit      = (cnt_q == half_len - 23'h000001);

	// Half period counter, restarted at each frame load
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			cnt_q <= 23'h000000;
		else if (restart_i || hit)
			cnt_q <= 23'h000000;
		else
			cnt_q <= cnt_q + 23'h000001;
	end

	// One-cycle tick at every half serial period
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			tick_o <= 1'b0;
		else
			tick_o <= hit && !restart_i;
	end
endmodule

// ==== design/clocked_serial_master_txrx.sv ====
`timescale 1ns/10ps
module clocked_serial_master_txrx
	import csm_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             serial_clock_pin_o,
	output logic             serial_output_pin_o,
	output logic             serial_output_pin_oe_o,
	input  wire logic        serial_input_pin_i,
	output logic             channel_transfer_irq_o
);
	`include "csm_regs.svh"

	ctrl_t       ctrl_q;
	baud_t       baud_q;
	xfer_state_t state_q;
	logic [4:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_en;
	logic        rd_take;
	logic        rd_data_now;
	logic        wr_mapped;
	logic        rd_mapped;
	logic [31:0] rd_word;
	logic [7:0]  tx_buf_q;
	logic        buffer_full_status_q;
	logic        enabled_q;
	logic [7:0]  serial_output_enable_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic [1:0]  irq_set;
	logic [7:0]  tx_sh_q;
	logic [7:0]  rx_sh_q;
	logic [7:0]  rx_next;
	logic [7:0]  rx_data_q;
	logic        rx_valid_q;
	logic [3:0]  k_q;
	logic [3:0]  k_last;
	logic        tick;
	logic        si_sync;
	logic        load;
	logic        done;
	logic        drive;
	logic        sample;
	logic        ev_xfer;
	logic        ev_ovr;
	logic        data_wr;

	// Bit leaving the transmit shifter for the chosen order and length
	function automatic logic out_bit(input logic [7:0] v, input ctrl_t c);
		out_bit = c.lsb_first ? v[0] : (c.len7 ? v[6] : v[7]);
	endfunction

	function automatic logic [7:0] shift_tx(input logic [7:0] v, input ctrl_t c);
		shift_tx = c.lsb_first ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
	endfunction

	// Pin input passes two stages before the shifter reads it
	in_sync u_si_sync
	(
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    (serial_input_pin_i),
		.sync_o     (si_sync)
	);

	// Half-period ticks, restarted when a frame loads
	baud_gen u_baud
	(
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.restart_i  (load),
		.baud_i     (baud_q),
		.tick_o     (tick)
	);

	// Bus decode and handshake terms
	assign wr_en       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign rd_take     = s_axi_arvalid && s_axi_arready;
	assign rd_data_now = rd_take && (s_axi_araddr == `CSM_OFS_DATA);
	assign wr_mapped   = (awaddr_q[1:0] == 2'h0);
	assign rd_mapped   = (s_axi_araddr[1:0] == 2'h0);
	assign data_wr     = wr_en && wstrb_q[0] && (awaddr_q == `CSM_OFS_DATA);

	// Write address channel, taken once and held until the response is taken
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_axi_awready <= 1'b1;
			awaddr_q      <= 5'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			awaddr_q      <= s_axi_awaddr;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_awready <= 1'b1;
	end

	// Write data channel, independent of the address channel
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_axi_wready <= 1'b1;
			wdata_q      <= 32'h00000000;
			wstrb_q      <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_wready <= 1'b1;
	end

	// Write response one cycle after both halves are held
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CSM_RESP_OKAY;
		end
		else if (wr_en)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_mapped) ? `CSM_RESP_OKAY : `CSM_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Configuration registers with byte lanes honoured
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctrl_q                 <= `CSM_CTRL_RST;
			baud_q                 <= `CSM_BAUD_RST;
			irq_mask_q             <= `CSM_MASK_RST;
			serial_output_enable_q <= 8'h00;
		end
		else if (wr_en)
		begin
			unique case (awaddr_q)
				`CSM_OFS_CTRL:
					if (wstrb_q[0])
						ctrl_q <= wdata_q[4:0];
				`CSM_OFS_BAUD:
				begin
					if (wstrb_q[0])
						baud_q.prescale_exp <= wdata_q[3:0];
					if (wstrb_q[1])
						baud_q.baud_divider_field <= wdata_q[15:8];
				end
				`CSM_OFS_IRQ_MASK:
					if (wstrb_q[0])
						irq_mask_q <= wdata_q[1:0];
				`CSM_OFS_OUT_EN:
					if (wstrb_q[0])
						serial_output_enable_q <= wdata_q[7:0];
				default:
					ctrl_q <= ctrl_q;
			endcase
		end
	end

	// Channel enable, set by its start bit; the second start bit has no channel
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			enabled_q <= 1'b0;
		else if (wr_en && wstrb_q[0] && awaddr_q == `CSM_OFS_START && wdata_q[0])
			enabled_q <= 1'b1;
	end

	// Transmit buffer; a write while full simply replaces the word
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_buf_q             <= 8'h00;
			buffer_full_status_q <= 1'b0;
		end
		else if (data_wr)
		begin
			tx_buf_q             <= wdata_q[7:0];
			buffer_full_status_q <= 1'b1;
		end
		else if (load)
			buffer_full_status_q <= 1'b0;
	end

	// Frame control terms
	assign k_last  = ctrl_q.len7 ? `CSM_LAST_K7 : `CSM_LAST_K8;
	assign load    = enabled_q && buffer_full_status_q && state_q == ST_IDLE;
	assign done    = state_q == ST_SHIFT && tick && k_q == k_last;
	assign drive   = state_q == ST_SHIFT && tick &&
		(ctrl_q.data_phase_select ? (k_q[0] && k_q != k_last) : !k_q[0]);
	assign sample  = state_q == ST_SHIFT && tick &&
		(ctrl_q.data_phase_select ? !k_q[0] : k_q[0]);
	assign rx_next = !sample ? rx_sh_q :
		(ctrl_q.lsb_first ? {si_sync, rx_sh_q[7:1]} : {rx_sh_q[6:0], si_sync});

	// Frame sequencer and half-period index
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_IDLE;
			k_q     <= 4'h0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (load)
					begin
						state_q <= ST_SHIFT;
						k_q     <= 4'h0;
					end
				ST_SHIFT:
					if (done)
						state_q <= ST_IDLE;
					else if (tick)
						k_q <= k_q + 4'h1;
			endcase
		end
	end

	// Serial clock toggles on every tick of a frame and rests at its idle level
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			serial_clock_pin_o <= 1'b1;
		else if (state_q == ST_SHIFT && tick)
			serial_clock_pin_o <= !serial_clock_pin_o;
		else if (state_q == ST_IDLE)
			serial_clock_pin_o <= !ctrl_q.clock_polarity_select;
	end

	// Transmit shifter; phase 1 puts the first bit out at load
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_sh_q             <= 8'h00;
			serial_output_pin_o <= 1'b0;
		end
		else if (load && ctrl_q.data_phase_select)
		begin
			serial_output_pin_o <= out_bit(tx_buf_q, ctrl_q);
			tx_sh_q             <= shift_tx(tx_buf_q, ctrl_q);
		end
		else if (load)
			tx_sh_q <= tx_buf_q;
		else if (drive)
		begin
			serial_output_pin_o <= out_bit(tx_sh_q, ctrl_q);
			tx_sh_q             <= shift_tx(tx_sh_q, ctrl_q);
		end
	end

	// Output enable follows the channel bit of the enable register
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			serial_output_pin_oe_o <= 1'b0;
		else
			serial_output_pin_oe_o <= serial_output_enable_q[0];
	end

	// Receive shifter and received word; the reader's clear loses to a new word
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_sh_q    <= 8'h00;
			rx_data_q  <= 8'h00;
			rx_valid_q <= 1'b0;
		end
		else
		begin
			rx_sh_q <= load ? 8'h00 : rx_next;
			if (done)
			begin
				rx_valid_q <= 1'b1;
				if (ctrl_q.len7)
					rx_data_q <= ctrl_q.lsb_first ? {1'b0, rx_next[7:1]} :
						{1'b0, rx_next[6:0]};
				else
					rx_data_q <= rx_next;
			end
			else if (rd_data_now)
				rx_valid_q <= 1'b0;
		end
	end

	// Event sources: mode picks the interrupt cause, overrun is the only error
	assign ev_xfer = ctrl_q.single_continuous_select ? load : done;
	assign ev_ovr  = done && rx_valid_q && !rd_data_now;
	assign irq_set = {ev_ovr, ev_xfer};

	// Sticky status, write one to clear, a new event wins
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			irq_stat_q <= 2'h0;
		else if (wr_en && wstrb_q[0] && awaddr_q == `CSM_OFS_IRQ_STAT)
			irq_stat_q <= (irq_stat_q & ~wdata_q[1:0]) | irq_set;
		else
			irq_stat_q <= irq_stat_q | irq_set;
	end

	// Level interrupt from unmasked status
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			channel_transfer_irq_o <= 1'b0;
		else
			channel_transfer_irq_o <= |(irq_stat_q & irq_mask_q);
	end

	// Read mux
	always_comb
	begin
		rd_word = 32'h00000000;
		unique case (s_axi_araddr)
			`CSM_OFS_DATA:     rd_word = {24'h000000, rx_data_q};
			`CSM_OFS_CTRL:     rd_word = {27'h0, ctrl_q};
			`CSM_OFS_BAUD:     rd_word = {16'h0000, baud_q.baud_divider_field, 4'h0,
				baud_q.prescale_exp};
			`CSM_OFS_STAT:     rd_word = {28'h0000000, enabled_q, rx_valid_q,
				state_q == ST_SHIFT, buffer_full_status_q};
			`CSM_OFS_IRQ_STAT: rd_word = {30'h0, irq_stat_q};
			`CSM_OFS_IRQ_MASK: rd_word = {30'h0, irq_mask_q};
			`CSM_OFS_OUT_EN:   rd_word = {24'h000000, serial_output_enable_q};
			default:           rd_word = 32'h00000000;
		endcase
	end

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `CSM_RESP_OKAY;
		end
		else if (rd_take)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_mapped ? `CSM_RESP_OKAY : `CSM_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// Serial clock moves only on a tick
	chk_clock_on_tick: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(state_q == ST_SHIFT && $past(state_q == ST_SHIFT) && !$past(tick))
		|-> $stable(serial_clock_pin_o))
		else $error("serial clock moved without a tick");

	chk_single_event: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(done && !ctrl_q.single_continuous_select) |=> irq_stat_q[`CSM_IRQ_XFER])
		else $error("frame end did not set the event in single mode");

	chk_irq_follows: assert property (@(posedge core_clk_i) disable iff (reset_i)
		##1 channel_transfer_irq_o == $past(|(irq_stat_q & irq_mask_q)))
		else $error("interrupt output does not follow masked status");

	chk_fastest_rate: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tick |=> !tick)
		else $error("serial half period shorter than two cycles");

	chk_idle_polarity: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(state_q == ST_IDLE && $past(state_q == ST_IDLE)
		&& $stable(ctrl_q.clock_polarity_select))
		|-> serial_clock_pin_o == !ctrl_q.clock_polarity_select)
		else $error("idle clock level does not match polarity");

	chk_lead_bit: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(load && ctrl_q.data_phase_select)
		|=> serial_output_pin_o == $past(out_bit(tx_buf_q, ctrl_q)))
		else $error("first bit not driven at load in phase 1");

	chk_overwrite: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(data_wr && buffer_full_status_q)
		|=> tx_buf_q == $past(wdata_q[7:0]) && buffer_full_status_q)
		else $error("write while full did not overwrite the buffer");

	chk_overrun_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(done && rx_valid_q && !rd_data_now)
		|=> irq_stat_q[`CSM_IRQ_OVR] && rx_valid_q)
		else $error("unread word was overrun without flag");

	chk_frame_ticks: assert property (@(posedge core_clk_i) disable iff (reset_i)
		load |=> state_q == ST_SHIFT && k_q == 4'h0 && !tick)
		else $error("frame did not start at index zero");

endmodule

// ==== verif/serial_slave_model.sv ====
`timescale 1ns/10ps
module serial_slave_model
(
	input  wire logic       sclk_i,
	input  wire logic       mosi_i,
	input  wire logic [4:0] cfg_i,
	input  wire logic       arm_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic [7:0]      rx_o
);
	int         n;
	logic [7:0] sh;

	// Slave bit due at frame position k
	function automatic logic pick(input int k);
		int nb;
		nb = cfg_i[4] ? 7 : 8;
		return cfg_i[3] ? tx_i[k] : tx_i[nb - 1 - k];
	endfunction

	// Start values
	initial
	begin
		miso_o = 1'b0;
		rx_o = 8'h00;
	end

	// Restart the count; phase 1 shows its first bit before the clock
	always @(posedge arm_i)
	begin
		n = 0;
		sh = 8'h00;
		miso_o <= #1 cfg_i[1] ? pick(0) : ~miso_o;
	end

	// Sample on one clock edge, drive on the other
	always @(sclk_i)
	begin
		if ((sclk_i === cfg_i[2]) == cfg_i[1])
		begin
			if (cfg_i[3])
				sh[n] = mosi_i;
			else
				sh = {sh[6:0], mosi_i};
			n = n + 1;
			if (n == (cfg_i[4] ? 7 : 8))
			begin
				rx_o = sh;
				n = 0;
				sh = 8'h00;
				// Released line shows the inverse in phase 0, not a held value; phase 1 shows the first bit again
				miso_o <= #1 cfg_i[1] ? pick(0) : ~miso_o;
			end
		end
		else
			miso_o <= #1 pick(n);
	end
endmodule

// ==== verif/clocked_serial_master_txrx_bench.sv ====
`timescale 1ns/10ps
`include "csm_regs.svh"
module clocked_serial_master_txrx_bench;
	typedef struct packed {
		logic [4:0]  ctrl;
		logic [15:0] baud;
		logic [7:0]  mtx;
		logic [7:0]  stx;
		logic [15:0] half;
	} row_t;
	logic        clk, rst, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
	logic        sclk, mosi, oe, miso, irq, arm;
	logic [4:0]  awa, ara, cfg;
	logic [31:0] wd, rd, d;
	logic [3:0]  ws;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  stx, srx;
	int          fails, n_checks, cyc;
	row_t        rows [7];

	clocked_serial_master_txrx clocked_serial_master_txrx_i
	(
		.core_clk_i(clk), .reset_i(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.serial_clock_pin_o(sclk), .serial_output_pin_o(mosi), .serial_output_pin_oe_o(oe),
		.serial_input_pin_i(miso), .channel_transfer_irq_o(irq)
	);

	serial_slave_model serial_slave_model_i
	(
		.sclk_i(sclk), .mosi_i(mosi), .cfg_i(cfg), .arm_i(arm), .tx_i(stx),
		.miso_o(miso), .rx_o(srx)
	);

	// Core clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Cut a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			$display("BAD %0t timeout", $time);
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		logic ta, tw;
		@(posedge clk);
		awa <= a;
		awv <= 1'b1;
		wd <= v;
		wv <= 1'b1;
		br <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		while (!(ta && tw))
		begin
			@(posedge clk);
			if (!ta && awr === 1'b1)
			begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (!tw && wr_r === 1'b1)
			begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (bv !== 1'b1);
		resp = bresp;
		br <= 1'b0;
	endtask

	// Bus read into d and resp
	task automatic rdv(input logic [4:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		d = rd;
		resp = rresp;
		rr <= 1'b0;
	endtask

	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		rdv(a);
		chk(d, e, "register");
	endtask

	// One single-mode frame from a table row
	task automatic frame(input row_t r);
		logic [7:0]  m;
		logic [31:0] h;
		logic        v;
		m = r.ctrl[4] ? 8'h7F : 8'hFF;
		cfg <= r.ctrl;
		stx <= r.stx;
		wr(`CSM_OFS_CTRL, {27'h0, r.ctrl});
		wr(`CSM_OFS_BAUD, {16'h0, r.baud});
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		wr(`CSM_OFS_DATA, {24'h0, r.mtx});
		// Spacing between two serial clock toggles
		h = 0;
		v = sclk;
		while (sclk === v) @(posedge clk);
		v = sclk;
		while (sclk === v)
		begin
			@(posedge clk);
			h++;
		end
		chk(h, {16'h0, r.half}, "half period");
		while (irq !== 1'b1) @(posedge clk);
		chk(srx, r.mtx & m, "slave rx");
		chk(sclk, !r.ctrl[2], "idle clock");
		rc(`CSM_OFS_IRQ_STAT, 32'h1);
		rdv(`CSM_OFS_DATA);
		if (r.half > 16'h0002)
			chk(d, {24'h0, r.stx & m}, "master rx");
		wr(`CSM_OFS_IRQ_STAT, 32'h1);
		rdv(`CSM_OFS_STAT);
		chk(irq, 0, "irq cleared");
		$display("done: frame ctrl %h", r.ctrl);
	endtask

	initial
	begin
		{rst, awv, wv, br, arv, rr, arm} = 7'h40;
		{awa, ara, cfg} = 15'h0;
		wd = 32'h0;
		ws = 4'hF;
		stx = 8'h00;
		rows = '{
			'{5'h00, 16'h0800, 8'h1E, 8'hC5, 16'h0005},
			'{5'h0A, 16'h0401, 8'h4B, 8'h3A, 16'h0006},
			'{5'h1C, 16'h0800, 8'hD3, 8'h2D, 16'h0005},
			'{5'h16, 16'h0800, 8'h65, 8'hB8, 16'h0005},
			'{5'h00, 16'h0000, 8'h81, 8'h00, 16'h0002},
			'{5'h06, 16'h0300, 8'h3C, 8'h5A, 16'h0002},
			'{5'h00, 16'hFF02, 8'h7E, 8'h99, 16'h0200}};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values and refused unaligned accesses
		rc(`CSM_OFS_CTRL, 32'h0);
		rc(`CSM_OFS_BAUD, 32'hFF00);
		rc(`CSM_OFS_STAT, 32'h0);
		rc(`CSM_OFS_IRQ_MASK, 32'h0);
		rc(`CSM_OFS_OUT_EN, 32'h0);
		chk(oe, 0, "oe at reset");
		rdv(5'h03);
		chk(resp, `CSM_RESP_SLVERR, "read resp");
		wr(5'h05, 32'h1);
		chk(resp, `CSM_RESP_SLVERR, "write resp");
		$display("done: reset");
		// No frame before the start bit
		wr(`CSM_OFS_OUT_EN, 32'h1);
		wr(`CSM_OFS_IRQ_MASK, 32'h1);
		chk(oe, 1, "oe set");
		wr(`CSM_OFS_DATA, 32'h5A);
		rc(`CSM_OFS_STAT, 32'h1);
		wr(`CSM_OFS_START, 32'h1);
		rc(`CSM_OFS_START, 32'h0);
		while (irq !== 1'b1) @(posedge clk);
		rdv(`CSM_OFS_DATA);
		wr(`CSM_OFS_IRQ_STAT, 32'h1);
		$display("done: start");
		for (int i = 0; i < 7; i++)
			frame(rows[i]);
		// Masked event holds the line low until unmasked
		wr(`CSM_OFS_IRQ_MASK, 32'h0);
		wr(`CSM_OFS_BAUD, 32'h0800);
		wr(`CSM_OFS_DATA, 32'h11);
		d = 32'h0;
		while (d[0] !== 1'b1) rdv(`CSM_OFS_IRQ_STAT);
		chk(irq, 0, "masked irq");
		wr(`CSM_OFS_IRQ_MASK, 32'h1);
		rdv(`CSM_OFS_DATA);
		chk(irq, 1, "unmasked irq");
		wr(`CSM_OFS_IRQ_STAT, 32'h1);
		rdv(`CSM_OFS_STAT);
		chk(irq, 0, "cleared irq");
		$display("done: mask");
		// Continuous: event on load, overwrite while full, then overrun
		stx <= 8'hC3;
		wr(`CSM_OFS_CTRL, 32'h1);
		wr(`CSM_OFS_IRQ_MASK, 32'h3);
		wr(`CSM_OFS_DATA, 32'h11);
		wr(`CSM_OFS_DATA, 32'h22);
		rc(`CSM_OFS_STAT, 32'hB);
		wr(`CSM_OFS_DATA, 32'h33);
		d = 32'h1;
		while (d[1:0] !== 2'h0) rdv(`CSM_OFS_STAT);
		chk(srx, 8'h33, "overwritten word");
		rc(`CSM_OFS_IRQ_STAT, 32'h3);
		chk(irq, 1, "continuous irq");
		rc(`CSM_OFS_DATA, 32'hC3);
		$display("done: continuous");
		// Mode switched to single while a continuous frame runs
		wr(`CSM_OFS_IRQ_STAT, 32'h3);
		wr(`CSM_OFS_DATA, 32'h55);
		wr(`CSM_OFS_IRQ_STAT, 32'h1);
		wr(`CSM_OFS_CTRL, 32'h0);
		d = 32'h0;
		while (d[0] !== 1'b1) rdv(`CSM_OFS_IRQ_STAT);
		rc(`CSM_OFS_STAT, 32'hC);
		$display("done: mode switch");
		// Reset in mid-frame puts the pins back to rest
		wr(`CSM_OFS_DATA, 32'h44);
		while (sclk === 1'b1) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		chk(sclk, 1, "clock in reset");
		chk(oe, 0, "oe in reset");
		chk(irq, 0, "irq in reset");
		rst <= 1'b0;
		rc(`CSM_OFS_STAT, 32'h0);
		rc(`CSM_OFS_IRQ_STAT, 32'h0);
		$display("done: second reset");
		summarize();
	end
endmodule
